// File: hdl/supervisor_consts.svh
/*
 Timing, reset and field constants for the reset supervisor and watchdog.
 Assumes a 125 MHz system clock; included by its bare name.
*/
// What this block does
// - Low manual reset input asserts reset outputs
// - Manual reset input is debounced internally
// - Reset held low while supply is low
// - Reset stretched 200 ms after trigger ends
// - Watchdog timeout never asserts reset itself
// - High reset output inverts low reset output
// - Timeout flag low when kick stays idle
// - Every kick edge clears watchdog counter
// - Watchdog counter held cleared during reset
// - Timeout flag stays low until counter cleared
// - Timeout flag low while supply is low
// - Warning output follows comparator result
// - Watchdog timeout nominally 1.6 seconds
// - New trigger during stretch restarts stretch
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and time units
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    8
`define NS_PER_MS        1000000
`define NS_PER_US        1000

// ----------------------------------------------------------------
// Documented and chosen times
// ----------------------------------------------------------------
`define STRETCH_TIME_MS  200
`define WATCHDOG_TIME_MS 1600
`define DEBOUNCE_TIME_US 1000

// ----------------------------------------------------------------
// Cycle counts derived from the times
// ----------------------------------------------------------------
`define STRETCH_CYCLES  ((`STRETCH_TIME_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WATCHDOG_CYCLES ((`WATCHDOG_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Input vector layout and reset values
// ----------------------------------------------------------------
`define PIN_COUNT        4
`define PIN_SYNC_INIT    4'he
`define RST_FLAG_N       1'h0
`define RST_WARN_N       1'h1
`define RST_RESET_N      1'h0

`endif

// File: hdl/supervisor_pkg.sv
/*
 Types used by the reset supervisor; its input synchroniser does not import them.
 Assumes nothing beyond the compile order.
*/
package supervisor_pkg;

    // ------------------------------------------------------------
    // Asynchronous inputs, most significant field first
    // ------------------------------------------------------------
    typedef struct packed {
        logic supply_low;
        logic supply_above;
        logic manual_reset_n;
        logic kick;
    } pins_t;

    // ------------------------------------------------------------
    // Reset sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RST_HOLD    = 2'b00,
        RST_STRETCH = 2'b01,
        RST_RUN     = 2'b10
    } rst_state_t;

endpackage : supervisor_pkg

// File: hdl/pin_sync.sv
/*
 Three-stage synchroniser for a vector of asynchronous pins.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int         WIDTH = 4,
    parameter logic [3:0] INIT  = 4'he
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pins,
    output var  logic [WIDTH-1:0] level
);

    // ------------------------------------------------------------
    // Per-bit synchroniser and agreement filter
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            logic lvl_d;

            always_comb begin
                lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q  <= INIT[i];
                    s2_q  <= INIT[i];
                    s3_q  <= INIT[i];
                    lvl_q <= INIT[i];
                end else begin
                    s1_q  <= pins[i];
                    s2_q  <= s1_q;
                    s3_q  <= s2_q;
                    lvl_q <= lvl_d;
                end
            end

            assign level[i] = lvl_q;
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// File: hdl/supervisor_reset_watchdog.sv
/*
 Reset supervisor with stretched reset, debounced manual reset,
 independent watchdog and supply warning pass-through.
 Assumes all four inputs are asynchronous to CLK and CLK runs at 125 MHz.
*/
`timescale 1ns/100ps
`default_nettype none

`include "supervisor_consts.svh"

module supervisor_reset_watchdog #(
    parameter int unsigned STRETCH_CYCLES  = `STRETCH_CYCLES,
    parameter int unsigned WATCHDOG_CYCLES = `WATCHDOG_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic SUPPLY_LOW_IN,
    input  wire logic SUPPLY_WARN_IN,
    input  wire logic MANUAL_RESET_N_IN,
    input  wire logic KICK_IN,
    output var  logic RESET_N_OUT,
    output var  logic RESET_OUT,
    output var  logic TIMEOUT_FLAG_N_OUT,
    output var  logic SUPPLY_WARN_N_OUT
);

    import supervisor_pkg::*;

    // ------------------------------------------------------------
    // Counter widths and terminal values
    // ------------------------------------------------------------
    localparam int STR_W = $clog2(STRETCH_CYCLES + 1);
    localparam int WD_W  = $clog2(WATCHDOG_CYCLES + 1);
    localparam int DB_W  = $clog2(DEBOUNCE_CYCLES + 1);

    localparam logic [STR_W-1:0] STR_LAST = STR_W'(STRETCH_CYCLES - 1);
    localparam logic [WD_W-1:0]  WD_LAST  = WD_W'(WATCHDOG_CYCLES);
    localparam logic [DB_W-1:0]  DB_LAST  = DB_W'(DEBOUNCE_CYCLES - 1);
    localparam logic [STR_W-1:0] STR_ONE  = STR_W'(1);
    localparam logic [WD_W-1:0]  WD_ONE   = WD_W'(1);
    localparam logic [DB_W-1:0]  DB_ONE   = DB_W'(1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pins_t            pins_raw;
    pins_t            pins_s;
    logic [3:0]       pins_vec;

    logic             mr_db_q;
    logic             mr_db_d;
    logic [DB_W-1:0]  db_cnt_q;
    logic [DB_W-1:0]  db_cnt_d;

    rst_state_t       state_q;
    rst_state_t       state_d;
    logic [STR_W-1:0] str_cnt_q;
    logic [STR_W-1:0] str_cnt_d;
    logic             trigger;

    logic             kick_prev_q;
    logic             kick_edge;
    logic [WD_W-1:0]  wd_cnt_q;
    logic [WD_W-1:0]  wd_cnt_d;
    logic             expired;

    logic             reset_n_d;
    logic             flag_n_d;
    logic             warn_n_d;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    always_comb begin
        pins_raw.supply_low     = SUPPLY_LOW_IN;
        pins_raw.supply_above   = SUPPLY_WARN_IN;
        pins_raw.manual_reset_n = MANUAL_RESET_N_IN;
        pins_raw.kick           = KICK_IN;
    end

    pin_sync #(
        .WIDTH (`PIN_COUNT),
        .INIT  (`PIN_SYNC_INIT)
    ) u_pin_sync (
        .clk     (CLK),
        .reset_n (RESET_N),
        .pins    (pins_raw),
        .level   (pins_vec)
    );

    assign pins_s = pins_t'(pins_vec);

    // ------------------------------------------------------------
    // Manual reset debounce
    // ------------------------------------------------------------
    always_comb begin
        mr_db_d  = mr_db_q;
        db_cnt_d = '0;
        if (pins_s.manual_reset_n != mr_db_q) begin
            if (db_cnt_q == DB_LAST) begin
                mr_db_d = pins_s.manual_reset_n;
            end else begin
                db_cnt_d = db_cnt_q + DB_ONE;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mr_db_q  <= 1'h1;
            db_cnt_q <= '0;
        end else begin
            mr_db_q  <= mr_db_d;
            db_cnt_q <= db_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    // Watchdog expiry is deliberately not a trigger
    assign trigger = pins_s.supply_low | ~mr_db_q;

    always_comb begin
        state_d   = state_q;
        str_cnt_d = str_cnt_q;
        unique case (state_q)
            RST_HOLD: begin
                str_cnt_d = '0;
                if (!trigger) begin
                    state_d = RST_STRETCH;
                end
            end
            RST_STRETCH: begin
                if (trigger) begin
                    state_d   = RST_HOLD;
                    str_cnt_d = '0;
                end else if (str_cnt_q == STR_LAST) begin
                    state_d   = RST_RUN;
                    str_cnt_d = '0;
                end else begin
                    str_cnt_d = str_cnt_q + STR_ONE;
                end
            end
            RST_RUN: begin
                if (trigger) begin
                    state_d = RST_HOLD;
                end
            end
            default: begin
                state_d   = RST_HOLD;
                str_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q   <= RST_HOLD;
            str_cnt_q <= '0;
        end else begin
            state_q   <= state_d;
            str_cnt_q <= str_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    assign kick_edge = pins_s.kick ^ kick_prev_q;
    assign expired   = (wd_cnt_q == WD_LAST);

    always_comb begin
        wd_cnt_d = wd_cnt_q;
        if (state_d != RST_RUN) begin
            wd_cnt_d = '0;
        end else if (kick_edge) begin
            wd_cnt_d = '0;
        end else if (!expired) begin
            wd_cnt_d = wd_cnt_q + WD_ONE;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            kick_prev_q <= 1'h0;
            wd_cnt_q    <= '0;
        end else begin
            kick_prev_q <= pins_s.kick;
            wd_cnt_q    <= wd_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_comb begin
        reset_n_d = (state_d == RST_RUN);
        // Expiry holds until the counter is cleared
        flag_n_d  = (wd_cnt_d != WD_LAST) & ~pins_s.supply_low;
        warn_n_d  = pins_s.supply_above;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESET_N_OUT        <= `RST_RESET_N;
            RESET_OUT          <= ~`RST_RESET_N;
            TIMEOUT_FLAG_N_OUT <= `RST_FLAG_N;
            SUPPLY_WARN_N_OUT  <= `RST_WARN_N;
        end else begin
            RESET_N_OUT        <= reset_n_d;
            RESET_OUT          <= ~reset_n_d;
            TIMEOUT_FLAG_N_OUT <= flag_n_d;
            SUPPLY_WARN_N_OUT  <= warn_n_d;
        end
    end

endmodule : supervisor_reset_watchdog

`default_nettype wire

// File: test/sup_wd_chk.sv
/* Assertions on the supervisor ports.
   Assumes one clock domain; bound to the top module. */
`timescale 1ns/100ps
`default_nettype none
module sup_wd_chk #(
    parameter int unsigned STRETCH_CYCLES  = 50,
    parameter int unsigned WATCHDOG_CYCLES = 100,
    parameter int unsigned DEBOUNCE_CYCLES = 8
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SUPPLY_LOW_IN,
    input wire logic SUPPLY_WARN_IN,
    input wire logic MANUAL_RESET_N_IN,
    input wire logic KICK_IN,
    input wire logic RESET_N_OUT,
    input wire logic RESET_OUT,
    input wire logic TIMEOUT_FLAG_N_OUT,
    input wire logic SUPPLY_WARN_N_OUT
);
    int unsigned quiet_q;
    int unsigned idle_q;
    int unsigned up_q;
    // ----
    // Cycle counters
    // ----
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            quiet_q <= 0;
            idle_q  <= 0;
            up_q    <= 0;
        end else begin
            quiet_q <= (SUPPLY_LOW_IN || !MANUAL_RESET_N_IN) ? 0 : quiet_q + 1;
            idle_q  <= (!RESET_N_OUT || $changed(KICK_IN)) ? 0 : idle_q + 1;
            up_q    <= (up_q < 15) ? up_q + 1 : up_q;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_low_held;
        SUPPLY_LOW_IN [*7];
    endsequence
    sequence s_warn_steady;
        (up_q > 8) ##0 $stable(SUPPLY_WARN_IN) [*7];
    endsequence
    // ----
    // Properties
    // ----
    chk_outputs_inverse: assert property (RESET_OUT == !RESET_N_OUT)
        else $error("reset outputs not inverse");
    chk_supply_holds: assert property (s_low_held |->
        !RESET_N_OUT && !TIMEOUT_FLAG_N_OUT) else $error("supply low ignored");
    chk_stretch_min: assert property ($rose(RESET_N_OUT) |->
        quiet_q >= STRETCH_CYCLES) else $error("stretch too short");
    chk_timeout_alone: assert property ($fell(TIMEOUT_FLAG_N_OUT) &&
        RESET_N_OUT |-> RESET_N_OUT [*4]) else $error("timeout gave reset");
    chk_early_flag: assert property (RESET_N_OUT && idle_q > 8 &&
        idle_q < WATCHDOG_CYCLES - 2 |-> TIMEOUT_FLAG_N_OUT)
        else $error("early timeout");
    chk_timeout_due: assert property (RESET_N_OUT &&
        idle_q == WATCHDOG_CYCLES + 8 |-> !TIMEOUT_FLAG_N_OUT)
        else $error("missed timeout");
    chk_flag_latched: assert property (RESET_N_OUT &&
        !TIMEOUT_FLAG_N_OUT && idle_q > 8 |=> !TIMEOUT_FLAG_N_OUT)
        else $error("flag released");
    chk_warn_follows: assert property (s_warn_steady |->
        SUPPLY_WARN_N_OUT == SUPPLY_WARN_IN) else $error("warn wrong");
    chk_warn_sync: assert property (up_q > 8 && $changed(SUPPLY_WARN_IN)
        |-> ##2 SUPPLY_WARN_N_OUT != SUPPLY_WARN_IN) else $error("no sync");
endmodule : sup_wd_chk
bind supervisor_reset_watchdog sup_wd_chk #(
    .STRETCH_CYCLES(STRETCH_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES),
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk (.CLK(CLK), .RESET_N(RESET_N),
    .SUPPLY_LOW_IN(SUPPLY_LOW_IN), .SUPPLY_WARN_IN(SUPPLY_WARN_IN),
    .MANUAL_RESET_N_IN(MANUAL_RESET_N_IN), .KICK_IN(KICK_IN),
    .RESET_N_OUT(RESET_N_OUT), .RESET_OUT(RESET_OUT),
    .TIMEOUT_FLAG_N_OUT(TIMEOUT_FLAG_N_OUT),
    .SUPPLY_WARN_N_OUT(SUPPLY_WARN_N_OUT));
`default_nettype wire

// File: test/host_model.sv
/* Host model toggling the kick pin.
   Assumes enable and gap change off the rising edge. */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic       rst_n_in,
    input  wire logic       en,
    input  wire logic [5:0] gap,
    output var  logic       kick
);
    int cnt = 0;
    initial kick = 1'b0;
    // ----
    // Kick at falling edge
    // ----
    always @(negedge clk) begin
        cnt <= cnt + 1;
        if (en && rst_n_in && cnt >= int'(gap)) begin
            kick <= ~kick;
            cnt  <= 0;
        end
    end
endmodule : host_model
`default_nettype wire

// File: test/tb_supervisor_reset_watchdog.sv
/* Bench for the supervisor with short counts.
   Assumes the host model drives the kick pin. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_supervisor_reset_watchdog;
    localparam int ST = 50;
    localparam int WD = 100;
    localparam int DB = 8;
    typedef struct {logic [2:0] v; int lo; int hi;} note_t;
    logic CLK = 0, RESET_N = 0, SUPPLY_LOW_IN = 0, SUPPLY_WARN_IN = 1;
    logic MANUAL_RESET_N_IN = 1, kick_en = 0;
    logic [5:0] kick_gap = 6'h10;
    logic [2:0] last_q = 3'h0;
    wire logic KICK_IN, RESET_N_OUT, RESET_OUT, TIMEOUT_FLAG_N_OUT;
    wire logic SUPPLY_WARN_N_OUT;
    wire logic [2:0] outs = {RESET_N_OUT, TIMEOUT_FLAG_N_OUT, SUPPLY_WARN_N_OUT};
    int err_count = 0, n_checks = 0, cyc = 0, seed = 88;
    note_t q[$];
    always #4 CLK = ~CLK;
    supervisor_reset_watchdog #(.STRETCH_CYCLES(ST), .WATCHDOG_CYCLES(WD),
        .DEBOUNCE_CYCLES(DB)) dut (.CLK(CLK), .RESET_N(RESET_N),
        .SUPPLY_LOW_IN(SUPPLY_LOW_IN), .SUPPLY_WARN_IN(SUPPLY_WARN_IN),
        .MANUAL_RESET_N_IN(MANUAL_RESET_N_IN), .KICK_IN(KICK_IN),
        .RESET_N_OUT(RESET_N_OUT), .RESET_OUT(RESET_OUT),
        .TIMEOUT_FLAG_N_OUT(TIMEOUT_FLAG_N_OUT),
        .SUPPLY_WARN_N_OUT(SUPPLY_WARN_N_OUT));
    host_model host (.clk(CLK), .rst_n_in(RESET_N_OUT), .en(kick_en),
        .gap(kick_gap), .kick(KICK_IN));
    // ----
    // Output watcher and timeout
    // ----
    always @(negedge CLK) begin
        note_t n;
        if (RESET_N && outs !== last_q) begin
            `CHK("reset_out", ~RESET_N_OUT, RESET_OUT)
            if (q.size() == 0) begin
                `CHK("stray", last_q, outs)
            end else begin
                n = q.pop_front();
                `CHK("outs", n.v, outs)
                `CHK("when", 1'b1, cyc >= n.lo && cyc <= n.hi)
            end
        end
        last_q = outs;
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            results();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic note_out(logic [2:0] v, int lo, int hi);
        q.push_back('{v, cyc + lo, cyc + hi});
    endtask : note_out
    task automatic drain(int n);
        repeat (n) begin
            @(negedge CLK);
            if (q.size() == 0) return;
        end
        `CHK("pending", 0, q.size())
        q.delete();
    endtask : drain
    task automatic idle(int n);
        repeat (n + ($random(seed) & 15)) @(negedge CLK);
    endtask : idle
    task automatic bounce(logic v);
        repeat (3) begin
            MANUAL_RESET_N_IN = v;
            repeat (3) @(negedge CLK);
            MANUAL_RESET_N_IN = ~v;
            repeat (3) @(negedge CLK);
        end
        MANUAL_RESET_N_IN = v;
    endtask : bounce
    task automatic do_reset(int n);
        RESET_N = 0;
        repeat (n) @(negedge CLK);
        RESET_N = 1;
        note_out(3'b011, 3, 8);
        note_out(3'b111, ST, ST + 12);
        drain(ST + 30);
    endtask : do_reset
    task automatic wd_check;
        note_out(3'b101, WD - 2, WD + 12);
        drain(WD + 20);
        idle(100);
        kick_en = 1;
        note_out(3'b111, 1, 50);
        drain(60);
    endtask : wd_check
    task automatic results;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    // ----
    // Main sequence
    // ----
    initial begin
        do_reset(6);
        wd_check();
        idle(300);
        repeat (4) begin
            SUPPLY_WARN_IN = 0;
            note_out(3'b110, 3, 7);
            idle(10);
            SUPPLY_WARN_IN = 1;
            note_out(3'b111, 3, 7);
            idle(10);
            kick_gap = 6'(8 + ($random(seed) & 31));
        end
        bounce(1'b0);
        note_out(3'b011, DB + 3, DB + 10);
        drain(30);
        MANUAL_RESET_N_IN = 1;
        repeat (25) @(negedge CLK);
        MANUAL_RESET_N_IN = 0;
        repeat (30) @(negedge CLK);
        bounce(1'b1);
        note_out(3'b111, ST + DB, ST + DB + 12);
        drain(ST + 40);
        SUPPLY_LOW_IN = 1;
        note_out(3'b001, 3, 7);
        drain(20);
        SUPPLY_LOW_IN = 0;
        note_out(3'b011, 3, 7);
        note_out(3'b111, ST, ST + 10);
        drain(ST + 30);
        kick_en = 0;
        do_reset(3);
        wd_check();
        results();
    end
endmodule : tb_supervisor_reset_watchdog
`default_nettype wire
